// ### coa_params.svh
// offsets, field positions, reset values and step sizes of the operand/alu core
// assumes inclusion by coa_pkg.sv and coa_core.sv
`ifndef COA_PARAMS_SVH
`define COA_PARAMS_SVH
// register indexes on the plain register port
`define COA_R_A 4'h0
`define COA_R_B 4'h1
`define COA_R_X 4'h2
`define COA_R_K 4'h3
`define COA_R_SP 4'h4
`define COA_R_PC 4'h5
`define COA_R_ACC_LO 4'h6
`define COA_R_ACC_HI 4'h7
`define COA_R_IMM 4'h8
`define COA_R_SADDR 4'h9
`define COA_R_DADDR 4'hA
`define COA_R_CMD 4'hB
`define COA_R_STAT 4'hC
`define COA_R_TBL 4'hD
// status bit positions
`define COA_ST_BUSY 0
`define COA_ST_SKIP 1
`define COA_ST_CY 2
`define COA_ST_OV 3
`define COA_ST_POS 4
`define COA_ST_NEG 5
// command word width
`define COA_CMD_W 10
// reset value of every data register
`define COA_RST_WORD 16'h0000
// pointer steps and operand masks
`define COA_STEP_BYTE 16'h0001
`define COA_STEP_WORD 16'h0002
`define COA_BYTE_MASK 16'h00FF
`define COA_WORD_MASK 16'hFFFF
// displacement widths: short jump -32..+31, relative call -1024..+1023
`define COA_SJMP_BITS 6
`define COA_RCALL_BITS 11
`endif

// ### coa_pkg.sv
// types shared by the operand/alu core and its testbench
// assumes coa_params.svh sits in the include path
`include "coa_params.svh"
package coa_pkg;
	// operations, coded by their order
	typedef enum logic [4:0] {
		OP_ADD, OP_ADD_CY, OP_SUB, OP_SUB_CY, OP_AND, OP_OR, OP_XOR,
		OP_UMUL, OP_UDIV, OP_LDIV, OP_T_EQ, OP_T_GT, OP_T_GE, OP_T_SGT,
		OP_T_SGE, OP_SMUL, OP_ACC, OP_ACC_Z, OP_SHR, OP_LD_STEP,
		OP_XCH_STEP, OP_BSET, OP_BCLR, OP_BTST, OP_BTSTN, OP_SJMP,
		OP_TCALL, OP_RCALL
	} coa_op_e;
	// sequencer states
	typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_WT, ST_CAP, ST_EXE, ST_WB} coa_state_e;
	// command word: ind[9] dst_mem[8] src_mem[7] dec[6] word[5] op[4:0]
	typedef struct packed {
		logic ind;
		logic dst_mem;
		logic src_mem;
		logic dec;
		logic word;
		coa_op_e op;
	} coa_cmd_s;
	// register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [15:0] wdata;
	} coa_bus_req_s;
	// memory request
	typedef struct packed {
		logic rd;
		logic wr;
		logic word;
		logic [15:0] addr;
		logic [15:0] wdata;
	} coa_mem_req_s;
endpackage : coa_pkg

// ### coa_core.sv
// operand addressing and arithmetic core: one command runs per CMD write
// assumes memory answers a read in the cycle after its strobe
//
// Functional notes
// - stepping pointer reads at B, steps 1/2
// - stepped B past K skips next
// - two direct address fields, source and destination
// - immediate operand, direct destination address
// - bit byte address is B plus X[15:3]
// - X[2:0] picks the bit
// - double register addressing for bit ops, 64k
// - short jump reaches -32..+31
// - table call picks among 16 entries
// - relative call reaches plus or minus 1k
// - exchange, step B, compare K, skip
// - bits set, cleared, tested, direct or indirect
// - add/subtract with carry update carry
// - unsigned product to dest and X, clears K,C
// - divide: quotient dest, remainder X, clears K,C
// - long divide from X:dest, carry updated
// - multiply/divide take immediate or memory source
// - unsigned compare skips when relation fails
// - signed compare skips when relation fails
// - and, or, xor write back to destination
// - clear accumulate zeros then adds signed product
// - overflow flags; B past K reloads from A
// - 32-bit accumulate result, signed product, shift
// - signed overflow and unsigned carry flags
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`include "coa_params.svh"
`timescale 1ns/1ps
`default_nettype none
module coa_core (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_N,
	// register port
	input wire coa_pkg::coa_bus_req_s BUS_REQ,
	output var logic [15:0] BUS_RDATA,
	// memory port
	output var coa_pkg::coa_mem_req_s MEM_REQ,
	input wire logic [15:0] MEM_RDATA
);
	import coa_pkg::*;

	coa_state_e state_reg;
	coa_cmd_s cmd_reg;
	coa_op_e op;
	logic [15:0] a_reg, b_reg, x_reg, k_reg, sp_reg, pc_reg;
	logic [15:0] imm_reg, saddr_reg, daddr_reg, tbl_reg, op1_reg, op2_reg;
	logic [31:0] accum_result_reg;
	logic c_reg, v_reg, skip_reg, rd_idx_reg;
	logic pos_overflow_flag_reg, neg_overflow_flag_reg;
	logic bus_wr, exe;
	logic is_dual, is_ptr, is_acc, is_bit, is_cmp, need1, need2, bword;
	logic [15:0] wmask, sv, dv, step_w, b_step, bit_addr, addr1, addr2;
	logic [2:0] bit_num;
	logic sub, cin, cy, ov, sg_d, sg_x, sg_r;
	logic [16:0] sum17;
	logic [15:0] sx, div_q, div_r;
	logic [31:0] prod_u, prod_s, mac_prod, acc_base, ldiv_n, ldiv_q, ldiv_r;
	logic [32:0] mac_sum;
	logic ldiv_ovf;
	logic [15:0] a_next, b_next, x_next, k_next, sp_next, pc_next, res;
	logic [15:0] wr_addr, wr_data, stat_w;
	logic [31:0] acc_next;
	logic c_next, v_next, skip_next, wr_en, pos_set, neg_set, past_k, bit_val;
	logic [7:0] bmask;

	// register writes are taken only while no command runs
	assign op = cmd_reg.op;
	assign bus_wr = BUS_REQ.wr && state_reg == ST_IDLE;
	assign exe = state_reg == ST_EXE;

	// decode: operand sources, read plan and addresses
	always_comb begin
		is_dual = op <= OP_SMUL;
		is_cmp = op inside {OP_T_EQ, OP_T_GT, OP_T_GE, OP_T_SGT, OP_T_SGE};
		is_acc = op inside {OP_ACC, OP_ACC_Z};
		is_ptr = is_acc || op inside {OP_LD_STEP, OP_XCH_STEP};
		is_bit = op inside {OP_BSET, OP_BCLR, OP_BTST, OP_BTSTN};
		need1 = (is_dual && cmd_reg.src_mem) || is_ptr || is_bit || op == OP_TCALL;
		need2 = (is_dual && cmd_reg.dst_mem) || is_acc;
		bword = is_acc || op inside {OP_TCALL, OP_RCALL} || (cmd_reg.word && !is_bit);
		wmask = bword ? `COA_WORD_MASK : `COA_BYTE_MASK;
		sv = (cmd_reg.src_mem ? op1_reg : imm_reg) & wmask;
		dv = (cmd_reg.dst_mem ? op2_reg : a_reg) & wmask;
		step_w = bword ? `COA_STEP_WORD : `COA_STEP_BYTE;
		b_step = cmd_reg.dec ? b_reg - step_w : b_reg + step_w;
		bit_addr = cmd_reg.ind ? b_reg + {3'h0, x_reg[15:3]} : daddr_reg;
		bit_num = cmd_reg.ind ? x_reg[2:0] : imm_reg[2:0];
		addr1 = saddr_reg;
		if (is_ptr) begin
			addr1 = b_reg;
		end else if (is_bit) begin
			addr1 = bit_addr;
		end else if (op == OP_TCALL) begin
			addr1 = tbl_reg + {11'h000, imm_reg[3:0], 1'b0};
		end
		addr2 = is_acc ? x_reg : daddr_reg;
	end

	// adder, products and quotients
	always_comb begin
		sub = op inside {OP_SUB, OP_SUB_CY};
		cin = (op inside {OP_ADD_CY, OP_SUB_CY}) ? c_reg : sub;
		sx = (sub ? ~sv : sv) & wmask;
		sum17 = {1'b0, dv} + {1'b0, sx} + {16'h0000, cin};
		cy = bword ? sum17[16] : sum17[8];
		sg_d = bword ? dv[15] : dv[7];
		sg_x = bword ? sx[15] : sx[7];
		sg_r = bword ? sum17[15] : sum17[7];
		ov = (sg_d == sg_x) && (sg_r != sg_d);
		prod_u = {16'h0000, dv} * {16'h0000, sv};
		prod_s = $signed({{16{dv[15]}}, dv}) * $signed({{16{sv[15]}}, sv});
		mac_prod = $signed({{16{op1_reg[15]}}, op1_reg})
			* $signed({{16{op2_reg[15]}}, op2_reg});
		acc_base = (op == OP_ACC_Z) ? 32'h00000000 : accum_result_reg;
		mac_sum = {acc_base[31], acc_base} + {mac_prod[31], mac_prod};
		div_q = `COA_WORD_MASK;
		div_r = dv;
		if (sv != 16'h0000) begin
			div_q = dv / sv;
			div_r = dv % sv;
		end
		ldiv_n = {x_reg, dv};
		ldiv_q = 32'hFFFFFFFF;
		ldiv_r = {16'h0000, dv};
		if (sv != 16'h0000) begin
			ldiv_q = ldiv_n / {16'h0000, sv};
			ldiv_r = ldiv_n % {16'h0000, sv};
		end
		ldiv_ovf = ldiv_q[31:16] != 16'h0000;
	end

	// execute: next values of every register the command touches
	always_comb begin
		a_next = a_reg;
		b_next = b_reg;
		x_next = x_reg;
		k_next = k_reg;
		sp_next = sp_reg;
		pc_next = pc_reg;
		acc_next = accum_result_reg;
		c_next = c_reg;
		v_next = v_reg;
		skip_next = 1'b0;
		pos_set = 1'b0;
		neg_set = 1'b0;
		res = dv;
		wr_en = 1'b0;
		wr_addr = daddr_reg;
		wr_data = res;
		bmask = 8'h01 << bit_num;
		bit_val = op1_reg[bit_num];
		past_k = cmd_reg.dec ? (b_step < k_reg) : (b_step > k_reg);
		case (op)
			OP_ADD, OP_ADD_CY, OP_SUB_CY: begin
				res = sum17[15:0] & wmask;
				c_next = cy;
				v_next = ov;
			end
			OP_SUB: begin
				res = sum17[15:0] & wmask;
				v_next = ov;
			end
			OP_AND: res = dv & sv;
			OP_OR: res = dv | sv;
			OP_XOR: res = dv ^ sv;
			OP_UMUL: begin
				res = prod_u[15:0];
				x_next = prod_u[31:16];
				k_next = `COA_RST_WORD;
				c_next = 1'b0;
			end
			OP_UDIV: begin
				res = div_q;
				x_next = div_r;
				k_next = `COA_RST_WORD;
				c_next = 1'b0;
			end
			OP_LDIV: begin
				res = ldiv_q[15:0];
				x_next = ldiv_r[15:0];
				k_next = `COA_RST_WORD;
				c_next = ldiv_ovf;
			end
			OP_T_EQ: skip_next = dv != sv;
			OP_T_GT: skip_next = !(dv > sv);
			OP_T_GE: skip_next = !(dv >= sv);
			OP_T_SGT: skip_next = !($signed(dv) > $signed(sv));
			OP_T_SGE: skip_next = !($signed(dv) >= $signed(sv));
			OP_SMUL: acc_next = prod_s;
			OP_ACC, OP_ACC_Z: begin
				acc_next = mac_sum[31:0];
				pos_set = !acc_base[31] && !mac_prod[31] && mac_sum[31];
				neg_set = acc_base[31] && mac_prod[31] && !mac_sum[31];
				b_next = b_reg + `COA_STEP_WORD;
				x_next = x_reg + `COA_STEP_WORD;
				if (b_reg + `COA_STEP_WORD > k_reg) begin
					b_next = a_reg;
				end
			end
			OP_SHR: acc_next = $signed(accum_result_reg) >>> imm_reg[4:0];
			OP_LD_STEP, OP_XCH_STEP: begin
				a_next = op1_reg & wmask;
				b_next = b_step;
				skip_next = past_k;
				wr_en = op == OP_XCH_STEP;
				wr_addr = b_reg;
				wr_data = a_reg;
			end
			OP_BSET, OP_BCLR: begin
				wr_en = 1'b1;
				wr_addr = addr1;
				wr_data = {8'h00, (op == OP_BSET) ? (op1_reg[7:0] | bmask) : (op1_reg[7:0] & ~bmask)};
			end
			OP_BTST: skip_next = !bit_val;
			OP_BTSTN: skip_next = bit_val;
			OP_SJMP: begin
				pc_next = pc_reg + {{(16 - `COA_SJMP_BITS){imm_reg[`COA_SJMP_BITS - 1]}},
					imm_reg[`COA_SJMP_BITS - 1:0]};
			end
			OP_TCALL, OP_RCALL: begin
				wr_en = 1'b1; // return address pushed at SP
				wr_addr = sp_reg;
				wr_data = pc_reg;
				sp_next = sp_reg + `COA_STEP_WORD;
				pc_next = op1_reg;
				if (op == OP_RCALL) begin
					pc_next = pc_reg + {{(16 - `COA_RCALL_BITS){imm_reg[`COA_RCALL_BITS - 1]}},
						imm_reg[`COA_RCALL_BITS - 1:0]};
				end
			end
			default: res = dv;
		endcase
		// two-operand results go to A or the direct destination
		if (is_dual && !is_cmp && op != OP_SMUL) begin
			if (cmd_reg.dst_mem) begin
				wr_en = 1'b1;
				wr_addr = daddr_reg;
				wr_data = res;
			end else begin
				a_next = res;
			end
		end
	end

	// sequencer: up to two reads, execute, optional write
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= ST_IDLE;
			rd_idx_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (bus_wr && BUS_REQ.addr == `COA_R_CMD) begin
						state_reg <= ST_RD;
						rd_idx_reg <= 1'b0;
					end
				end
				ST_RD: begin
					if (rd_idx_reg ? need2 : need1) begin
						state_reg <= ST_WT;
					end else if (!rd_idx_reg) begin
						rd_idx_reg <= 1'b1;
					end else begin
						state_reg <= ST_EXE;
					end
				end
				ST_WT: state_reg <= ST_CAP;
				ST_CAP: begin
					if (!rd_idx_reg) begin
						rd_idx_reg <= 1'b1;
						state_reg <= ST_RD;
					end else begin
						state_reg <= ST_EXE;
					end
				end
				ST_EXE: state_reg <= wr_en ? ST_WB : ST_IDLE;
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// memory strobes, one cycle each
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			MEM_REQ <= '0;
		end else begin
			MEM_REQ.rd <= 1'b0;
			MEM_REQ.wr <= 1'b0;
			if (state_reg == ST_RD && (rd_idx_reg ? need2 : need1)) begin
				MEM_REQ.rd <= 1'b1;
				MEM_REQ.word <= bword;
				MEM_REQ.addr <= rd_idx_reg ? addr2 : addr1;
			end else if (exe && wr_en) begin
				MEM_REQ.wr <= 1'b1;
				MEM_REQ.word <= bword && !is_bit;
				MEM_REQ.addr <= wr_addr;
				MEM_REQ.wdata <= wr_data;
			end
		end
	end

	// read data capture
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			op1_reg <= `COA_RST_WORD;
			op2_reg <= `COA_RST_WORD;
		end else if (state_reg == ST_CAP) begin
			if (rd_idx_reg) begin
				op2_reg <= MEM_RDATA;
			end else begin
				op1_reg <= MEM_RDATA;
			end
		end
	end

	// cpu registers and command word
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			a_reg <= `COA_RST_WORD;
			b_reg <= `COA_RST_WORD;
			x_reg <= `COA_RST_WORD;
			k_reg <= `COA_RST_WORD;
			sp_reg <= `COA_RST_WORD;
			pc_reg <= `COA_RST_WORD;
			imm_reg <= `COA_RST_WORD;
			saddr_reg <= `COA_RST_WORD;
			daddr_reg <= `COA_RST_WORD;
			tbl_reg <= `COA_RST_WORD;
			cmd_reg <= '0;
		end else if (exe) begin
			a_reg <= a_next;
			b_reg <= b_next;
			x_reg <= x_next;
			k_reg <= k_next;
			sp_reg <= sp_next;
			pc_reg <= pc_next;
		end else if (bus_wr) begin
			case (BUS_REQ.addr)
				`COA_R_A: a_reg <= BUS_REQ.wdata;
				`COA_R_B: b_reg <= BUS_REQ.wdata;
				`COA_R_X: x_reg <= BUS_REQ.wdata;
				`COA_R_K: k_reg <= BUS_REQ.wdata;
				`COA_R_SP: sp_reg <= BUS_REQ.wdata;
				`COA_R_PC: pc_reg <= BUS_REQ.wdata;
				`COA_R_IMM: imm_reg <= BUS_REQ.wdata;
				`COA_R_SADDR: saddr_reg <= BUS_REQ.wdata;
				`COA_R_DADDR: daddr_reg <= BUS_REQ.wdata;
				`COA_R_TBL: tbl_reg <= BUS_REQ.wdata;
				`COA_R_CMD: cmd_reg <= coa_cmd_s'(BUS_REQ.wdata[`COA_CMD_W - 1:0]);
				default: a_reg <= a_reg;
			endcase
		end
	end

	// accumulate result register and its sticky overflow flags
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			accum_result_reg <= 32'h00000000;
			pos_overflow_flag_reg <= 1'b0;
			neg_overflow_flag_reg <= 1'b0;
		end else if (exe) begin
			accum_result_reg <= acc_next;
			pos_overflow_flag_reg <= pos_overflow_flag_reg || pos_set;
			neg_overflow_flag_reg <= neg_overflow_flag_reg || neg_set;
		end else if (bus_wr) begin
			if (BUS_REQ.addr == `COA_R_ACC_LO) begin
				accum_result_reg[15:0] <= BUS_REQ.wdata;
			end
			if (BUS_REQ.addr == `COA_R_ACC_HI) begin
				accum_result_reg[31:16] <= BUS_REQ.wdata;
			end
			if (BUS_REQ.addr == `COA_R_STAT) begin
				pos_overflow_flag_reg <= BUS_REQ.wdata[`COA_ST_POS];
				neg_overflow_flag_reg <= BUS_REQ.wdata[`COA_ST_NEG];
			end
		end
	end

	// carry, overflow and skip flags
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			c_reg <= 1'b0;
			v_reg <= 1'b0;
			skip_reg <= 1'b0;
		end else if (exe) begin
			c_reg <= c_next;
			v_reg <= v_next;
			skip_reg <= skip_next;
		end else if (bus_wr && BUS_REQ.addr == `COA_R_STAT) begin
			c_reg <= BUS_REQ.wdata[`COA_ST_CY];
			v_reg <= BUS_REQ.wdata[`COA_ST_OV];
			skip_reg <= BUS_REQ.wdata[`COA_ST_SKIP];
		end
	end

	// status word
	always_comb begin
		stat_w = 16'h0000;
		stat_w[`COA_ST_BUSY] = state_reg != ST_IDLE;
		stat_w[`COA_ST_SKIP] = skip_reg;
		stat_w[`COA_ST_CY] = c_reg;
		stat_w[`COA_ST_OV] = v_reg;
		stat_w[`COA_ST_POS] = pos_overflow_flag_reg;
		stat_w[`COA_ST_NEG] = neg_overflow_flag_reg;
	end

	// read data, valid the cycle after the read strobe
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			BUS_RDATA <= 16'h0000;
		end else if (BUS_REQ.rd) begin
			case (BUS_REQ.addr)
				`COA_R_A: BUS_RDATA <= a_reg;
				`COA_R_B: BUS_RDATA <= b_reg;
				`COA_R_X: BUS_RDATA <= x_reg;
				`COA_R_K: BUS_RDATA <= k_reg;
				`COA_R_SP: BUS_RDATA <= sp_reg;
				`COA_R_PC: BUS_RDATA <= pc_reg;
				`COA_R_ACC_LO: BUS_RDATA <= accum_result_reg[15:0];
				`COA_R_ACC_HI: BUS_RDATA <= accum_result_reg[31:16];
				`COA_R_IMM: BUS_RDATA <= imm_reg;
				`COA_R_SADDR: BUS_RDATA <= saddr_reg;
				`COA_R_DADDR: BUS_RDATA <= daddr_reg;
				`COA_R_CMD: BUS_RDATA <= {6'h00, cmd_reg};
				`COA_R_STAT: BUS_RDATA <= stat_w;
				`COA_R_TBL: BUS_RDATA <= tbl_reg;
				default: BUS_RDATA <= 16'h0000;
			endcase
		end else begin
			BUS_RDATA <= 16'h0000;
		end
	end

	// checks
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	a_step_up: assert property (exe && op == OP_LD_STEP && !cmd_reg.dec |=>
		b_reg == $past(b_reg) + $past(step_w)) else $error("pointer step wrong");
	a_bound_skip: assert property (exe && op inside {OP_LD_STEP, OP_XCH_STEP} |=>
		skip_reg == (cmd_reg.dec ? b_reg < k_reg : b_reg > k_reg)) else $error("bound skip wrong");
	a_bit_addr: assert property (state_reg == ST_WT && is_bit && cmd_reg.ind |->
		MEM_REQ.rd && MEM_REQ.addr == b_reg + {3'h0, x_reg[15:3]}) else $error("bit address wrong");
	a_umul_clear: assert property (exe && op == OP_UMUL && !cmd_reg.dst_mem |=>
		{x_reg, a_reg} == $past(prod_u) && k_reg == 16'h0000 && !c_reg) else $error("product wrong");
	a_sjmp_reach: assert property (exe && op == OP_SJMP |=>
		($signed(pc_reg - $past(pc_reg)) >= -32) && ($signed(pc_reg - $past(pc_reg)) <= 31))
		else $error("short jump out of reach");
	a_accz_start: assert property (exe && op == OP_ACC_Z |=>
		accum_result_reg == $past(mac_prod)) else $error("clear accumulate wrong");
	a_eq_skip: assert property (exe && op == OP_T_EQ |=>
		skip_reg == ($past(dv) != $past(sv))) else $error("equal compare wrong");
	a_xch_write: assert property (exe && op == OP_XCH_STEP |=>
		MEM_REQ.wr && MEM_REQ.wdata == $past(a_reg) && MEM_REQ.addr == $past(b_reg) ##1 !MEM_REQ.wr)
		else $error("exchange write wrong");
	a_read_turn: assert property (MEM_REQ.rd |=> !MEM_REQ.rd ##1 state_reg != ST_WT)
		else $error("read sequence wrong");
endmodule : coa_core
`default_nettype wire

// ### coa_mem_model.sv
// memory model that answers the core's memory port
// assumes a read is answered in the cycle after its strobe; words are stored low byte first
`timescale 1ns/1ps
`default_nettype none
module coa_mem_model (
	// clock
	input wire logic SYS_CLK,
	// memory port
	input wire coa_pkg::coa_mem_req_s MEM_REQ,
	output var logic [15:0] MEM_RDATA
);
	import coa_pkg::*;
	logic [7:0] mem [0:65535];
	// bench access to stored words
	task automatic put(input logic [15:0] a, input logic [15:0] d);
		mem[a] = d[7:0];
		mem[16'(a + 16'h0001)] = d[15:8];
	endtask : put
	function automatic logic [15:0] get(input logic [15:0] a);
		return {mem[16'(a + 16'h0001)], mem[a]};
	endfunction : get
	// empty memory reads as zero
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'h00;
		end
		MEM_RDATA = 16'h0000;
	end
	// one-cycle read answer, scrambled bus otherwise, byte or word writes
	always @(posedge SYS_CLK) begin
		if (MEM_REQ.rd) begin
			MEM_RDATA <= MEM_REQ.word ? get(MEM_REQ.addr) : {~mem[MEM_REQ.addr], mem[MEM_REQ.addr]};
		end else begin
			MEM_RDATA <= ~MEM_RDATA; // stale data never lingers
		end
		if (MEM_REQ.wr) begin
			mem[MEM_REQ.addr] <= MEM_REQ.wdata[7:0];
			if (MEM_REQ.word) begin
				mem[16'(MEM_REQ.addr + 16'h0001)] <= MEM_REQ.wdata[15:8];
			end
		end
	end
endmodule : coa_mem_model
`default_nettype wire

// ### coa_core_tb.sv
// self-checking bench for the operand/alu core with a memory model behind it
// assumes reads answer one cycle late and a command finishes within 10 cycles
`include "coa_params.svh"
`timescale 1ns/1ps
`default_nettype none
module coa_core_tb;
	import coa_pkg::*;
	logic SYS_CLK;
	logic RST_N;
	coa_bus_req_s bus_req;
	logic [15:0] bus_rdata;
	coa_mem_req_s mem_req;
	logic [15:0] mem_rdata;
	logic [15:0] exp_q [$];
	logic rd_seen;
	int failures;
	int checks;
	int md;
	logic [15:0] a, b, bb, x, r, m;
	logic [16:0] s;
	logic [31:0] p;
	logic c, v, cy, ok;
	coa_op_e op;
	coa_op_e bops [6] = '{OP_BSET, OP_BTST, OP_BTSTN, OP_BCLR, OP_BTST, OP_BTSTN};
	// design and memory
	coa_core u_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .BUS_REQ(bus_req), .BUS_RDATA(bus_rdata),
		.MEM_REQ(mem_req), .MEM_RDATA(mem_rdata));
	coa_mem_model u_mem (.SYS_CLK(SYS_CLK), .MEM_REQ(mem_req), .MEM_RDATA(mem_rdata));
	// clock
	initial begin
		SYS_CLK = 1'b0;
		forever #4 SYS_CLK = ~SYS_CLK;
	end
	task automatic cmp_reg(input logic [15:0] got, input logic [15:0] e);
		checks++;
		if (got !== e) begin
			failures++;
			$display("CHECK FAILED t=%0t reg got=%h exp=%h", $time, got, e);
		end
	endtask : cmp_reg
	task automatic cmp_mem(input logic [15:0] ad, input logic [15:0] e);
		checks++;
		if (u_mem.get(ad) !== e) begin
			failures++;
			$display("CHECK FAILED t=%0t mem got=%h exp=%h", $time, u_mem.get(ad), e);
		end
	endtask : cmp_mem
	// watcher: the cycle after a read strobe takes the oldest note
	always @(posedge SYS_CLK) begin
		if (rd_seen) begin
			cmp_reg(bus_rdata, (exp_q.size() > 0) ? exp_q.pop_front() : 16'hXXXX);
		end
		rd_seen <= bus_req.rd;
	end
	task automatic wr(input logic [3:0] ad, input logic [15:0] d);
		@(posedge SYS_CLK);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: d};
		@(posedge SYS_CLK);
		bus_req <= '0;
	endtask : wr
	task automatic rd(input logic [3:0] ad, input logic [15:0] e);
		exp_q.push_back(e);
		@(posedge SYS_CLK);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 16'h0000};
		@(posedge SYS_CLK);
		bus_req <= '0;
	endtask : rd
	function automatic coa_cmd_s mk(input logic ind, dm, sm, dec, wd, input coa_op_e o);
		return '{ind, dm, sm, dec, wd, o};
	endfunction : mk
	// preset flags, start a command, let it finish
	task automatic go(input coa_cmd_s k, input logic [15:0] st);
		wr(`COA_R_STAT, st);
		wr(`COA_R_CMD, {6'h00, k});
		repeat (11) @(posedge SYS_CLK);
	endtask : go
	task automatic wrap_up;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up
	// hang guard
	initial begin
		#200000;
		failures++;
		wrap_up();
	end
	// main sequence
	initial begin
		RST_N = 1'b0;
		bus_req = '0;
		rd_seen = 1'b0;
		failures = 0;
		checks = 0;
		repeat (3) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		void'($urandom(32'h89D5B872));
		for (int i = 0; i < 16; i++) begin
			rd(4'(i), 16'h0000);
		end
		$display("test reset done");
		// add, subtract and logic ops, four operand modes, random operands and carry
		for (int i = 0; i < 28; i++) begin
			op = coa_op_e'(i % 7);
			md = i / 7;
			a = 16'($urandom);
			b = 16'($urandom);
			cy = 1'($urandom);
			x = 16'($urandom) & 16'hFEFE;
			wr(`COA_R_A, a);
			wr(`COA_R_IMM, b);
			wr(`COA_R_SADDR, x);
			wr(`COA_R_DADDR, x ^ 16'h0100);
			u_mem.put(x, b);
			u_mem.put(x ^ 16'h0100, a);
			m = (md == 3) ? 16'h00FF : 16'hFFFF;
			go(mk(1'b0, md[1], md[0], 1'b0, md != 3, op), {13'h0000, cy, 2'b00});
			bb = ((op == OP_SUB || op == OP_SUB_CY) ? ~b : b) & m;
			s = {1'b0, a & m} + {1'b0, bb};
			s = s + ((op == OP_ADD) ? 17'h0 : (op == OP_SUB) ? 17'h1 : {16'h0, cy});
			v = (op <= OP_SUB_CY) && (m[8] ? (a[15] == bb[15]) && (s[15] != a[15]) :
				(a[7] == bb[7]) && (s[7] != a[7]));
			c = (op <= OP_SUB_CY && op != OP_SUB) ? (m[8] ? s[16] : s[8]) : cy;
			r = (op == OP_AND) ? a & b : (op == OP_OR) ? a | b : (op == OP_XOR) ? a ^ b : s[15:0];
			r = r & m;
			if (md[1]) begin
				cmp_mem(x ^ 16'h0100, r | (a & ~m));
			end else begin
				rd(`COA_R_A, r);
			end
			rd(`COA_R_STAT, {12'h000, v, c, 2'b00});
		end
		$display("test arithmetic done");
		// multiply and divide, immediate and memory source, long divide overflow
		for (int i = 0; i < 6; i++) begin
			op = (i < 2) ? OP_UMUL : (i < 4) ? OP_UDIV : OP_LDIV;
			a = 16'($urandom);
			b = 16'($urandom) | 16'h0001;
			x = (i == 5) ? b : b >> 1;
			wr(`COA_R_A, a);
			wr(`COA_R_X, x);
			wr(`COA_R_K, 16'h5A5A);
			wr(`COA_R_IMM, b);
			wr(`COA_R_SADDR, 16'h0040);
			u_mem.put(16'h0040, b);
			go(mk(1'b0, 1'b0, i[0], 1'b0, 1'b1, op), 16'h0004);
			p = (op == OP_UMUL) ? {16'h0, a} * {16'h0, b} : (op == OP_UDIV) ?
				{16'(a % b), 16'(a / b)} : {16'({x, a} % {16'h0, b}), 16'({x, a} / {16'h0, b})};
			if (i != 5) begin
				rd(`COA_R_A, p[15:0]);
				rd(`COA_R_X, p[31:16]);
			end
			rd(`COA_R_K, 16'h0000);
			rd(`COA_R_STAT, (i == 5) ? 16'h0004 : 16'h0000);
		end
		$display("test multiply divide done");
		// unsigned and signed compares across the sign boundary
		for (int i = 0; i < 20; i++) begin
			op = coa_op_e'(int'(OP_T_EQ) + i % 5);
			md = i / 5;
			a = (md == 2) ? 16'h7FFF : (md == 3) ? 16'($urandom) : 16'h8000;
			b = (md == 1) ? 16'h7FFF : (md == 3) ? 16'($urandom) : 16'h8000;
			wr(`COA_R_A, a);
			wr(`COA_R_IMM, b);
			go(mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, op), 16'h0000);
			ok = (op == OP_T_EQ) ? a == b : (op == OP_T_GT) ? a > b : (op == OP_T_GE) ? a >= b :
				(op == OP_T_SGT) ? $signed(a) > $signed(b) : $signed(a) >= $signed(b);
			rd(`COA_R_STAT, {14'h0000, ~ok, 1'b0});
		end
		$display("test compare done");
		// load and exchange with pointer step, at and just past the bound
		for (int i = 0; i < 8; i++) begin
			x = i[1] ? (i[0] ? 16'h02FF : 16'h0300) : (i[0] ? 16'h0202 : 16'h0200);
			a = 16'($urandom);
			b = 16'($urandom);
			wr(`COA_R_A, a);
			wr(`COA_R_B, x);
			wr(`COA_R_K, i[1] ? 16'h02FF : 16'h0202);
			u_mem.put(x, b);
			go(mk(1'b0, 1'b0, 1'b0, i[1], ~i[1], i[2] ? OP_XCH_STEP : OP_LD_STEP), 16'h0000);
			rd(`COA_R_A, i[1] ? {8'h00, b[7:0]} : b);
			rd(`COA_R_B, i[1] ? x - 16'h0001 : x + 16'h0002);
			rd(`COA_R_STAT, {14'h0000, i[0], 1'b0});
			if (i[2]) begin
				cmp_mem(x, i[1] ? {b[15:8], a[7:0]} : a);
			end
		end
		$display("test step done");
		// bit ops through B and X at the top of the index range, then one direct
		r = 16'hC35A;
		wr(`COA_R_B, 16'h0400);
		wr(`COA_R_X, 16'hFFF5);
		u_mem.put(16'h23FE, r);
		for (int i = 0; i < 6; i++) begin
			go(mk(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, bops[i]), 16'h0000);
			r[5] = (bops[i] == OP_BSET) ? 1'b1 : (bops[i] == OP_BCLR) ? 1'b0 : r[5];
			cmp_mem(16'h23FE, r);
			ok = (bops[i] == OP_BTST) ? ~r[5] : (bops[i] == OP_BTSTN) ? r[5] : 1'b0;
			rd(`COA_R_STAT, {14'h0000, ok, 1'b0});
		end
		wr(`COA_R_DADDR, 16'h0031);
		wr(`COA_R_IMM, 16'hFFFB);
		go(mk(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, OP_BSET), 16'h0000);
		cmp_mem(16'h0030, 16'h0800);
		$display("test bits done");
		// jump and calls at their reach limits
		wr(`COA_R_PC, 16'h1000);
		wr(`COA_R_IMM, 16'hFFE0);
		go(mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, OP_SJMP), 16'h0000);
		rd(`COA_R_PC, 16'h0FE0);
		wr(`COA_R_IMM, 16'h001F);
		go(mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, OP_SJMP), 16'h0000);
		rd(`COA_R_PC, 16'h0FFF);
		wr(`COA_R_SP, 16'h0100);
		wr(`COA_R_IMM, 16'h0400);
		go(mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, OP_RCALL), 16'h0000);
		rd(`COA_R_PC, 16'h0BFF);
		cmp_mem(16'h0100, 16'h0FFF);
		wr(`COA_R_TBL, 16'h0600);
		wr(`COA_R_IMM, 16'hFFFF);
		u_mem.put(16'h061E, 16'h2468);
		go(mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, OP_TCALL), 16'h0000);
		rd(`COA_R_PC, 16'h2468);
		cmp_mem(16'h0102, 16'h0BFF);
		rd(`COA_R_SP, 16'h0104);
		$display("test calls done");
		// signed product, shift, clear-and-accumulate with reload, then accumulate
		a = 16'($urandom);
		b = 16'($urandom);
		wr(`COA_R_A, a);
		wr(`COA_R_IMM, b);
		go(mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, OP_SMUL), 16'h0000);
		p = $signed(a) * $signed(b);
		rd(`COA_R_ACC_LO, p[15:0]);
		rd(`COA_R_ACC_HI, p[31:16]);
		wr(`COA_R_IMM, 16'h0004);
		go(mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, OP_SHR), 16'h0000);
		p = $signed(p) >>> 4;
		rd(`COA_R_ACC_LO, p[15:0]);
		rd(`COA_R_ACC_HI, p[31:16]);
		x = 16'($urandom);
		wr(`COA_R_B, 16'h0700);
		wr(`COA_R_X, 16'h0800);
		wr(`COA_R_K, 16'h0701);
		wr(`COA_R_A, 16'h0123);
		u_mem.put(16'h0700, a);
		u_mem.put(16'h0800, b);
		u_mem.put(16'h0802, x);
		go(mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, OP_ACC_Z), 16'h0000);
		p = $signed(a) * $signed(b);
		rd(`COA_R_ACC_LO, p[15:0]);
		rd(`COA_R_ACC_HI, p[31:16]);
		rd(`COA_R_B, 16'h0123);
		rd(`COA_R_X, 16'h0802);
		wr(`COA_R_B, 16'h0700);
		wr(`COA_R_K, 16'hFFFF);
		go(mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, OP_ACC), 16'h0000);
		p = p + {{16{a[15]}}, a} * {{16{x[15]}}, x};
		rd(`COA_R_ACC_LO, p[15:0]);
		rd(`COA_R_ACC_HI, p[31:16]);
		rd(`COA_R_B, 16'h0702);
		wr(`COA_R_ACC_HI, 16'h7FFF);
		wr(`COA_R_ACC_LO, 16'hFFFF);
		wr(`COA_R_X, 16'h0800);
		u_mem.put(16'h0702, 16'h0001);
		u_mem.put(16'h0800, 16'h0001);
		u_mem.put(16'h0802, 16'h0001);
		u_mem.put(16'h0704, 16'hFFFF);
		go(mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, OP_ACC), 16'h0000);
		rd(`COA_R_STAT, 16'h0010);
		rd(`COA_R_ACC_HI, 16'h8000);
		go(mk(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, OP_ACC), 16'h0000);
		rd(`COA_R_STAT, 16'h0020);
		rd(`COA_R_ACC_HI, 16'h7FFF);
		$display("test accumulate done");
		repeat (3) @(posedge SYS_CLK);
		wrap_up();
	end
endmodule : coa_core_tb
`default_nettype wire
